// [rtl/dual_adc_io_defs.svh]
// constants for the dual converter serial data and configuration port
`ifndef DUAL_ADC_IO_DEFS_SVH
`define DUAL_ADC_IO_DEFS_SVH
// ==================================================================
// field widths
`define RES_W        16
`define CODE_W       3
`define CFG_W        6
`define CHAN_FRAME_W 19
`define FRAME_W      38
// ==================================================================
// frame bit positions: channel 0 in upper half, result before code
`define LANE0_MSB    37
`define LANE1_MSB    18
// ==================================================================
// reset and fixed values
`define CFG_RESET    6'h3f
`define CODE_OFF     3'h0
`define CODE_TWOS_B  1
// ==================================================================
// timing: conversion time in ns, cycle count rounded up
`define CLK_PERIOD_NS 5
`define CONV_TIME_NS  500
`define CONV_CYCLES \
  ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_CNT_W    8
// ==================================================================
// pin synchroniser slots
`define PIN_N        7
`define PIN_CNV      0
`define PIN_CS_N     1
`define PIN_SCK      2
`define PIN_SDI      3
`define PIN_DSCK     4
`define PIN_DSDI     5
`define PIN_MODE     6
`endif

// [rtl/dual_adc_io_pkg.sv]
// types shared by the dual converter serial port
package dual_adc_io_pkg;
  // raw converter results for both channels, offset binary
  typedef struct packed {
    logic [15:0] chan1;
    logic [15:0] chan0;
  } sample_pair_type;
  // range codes in force for the current results
  typedef struct packed {
    logic [2:0] chan1;
    logic [2:0] chan0;
  } range_pair_type;
  // conversion sequencer
  typedef enum logic {CONV_IDLE, CONV_RUN} conv_state_type;
endpackage

// [rtl/dual_adc_serial_io_config.sv]
// serial data and configuration port of a dual 16-bit converter
`timescale 1ns/100ps
`include "dual_adc_io_defs.svh"

module dual_adc_serial_io_config
#(
  parameter int CONV_CYCLES = `CONV_CYCLES
)
(
  // clock and reset
  input  wire logic                              i_core_clk,
  input  wire logic                              i_rst_n,
  // converter core
  input  wire dual_adc_io_pkg::sample_pair_type  i_samples,
  input  wire logic                              i_convert_request,
  output logic                                   o_busy,
  output dual_adc_io_pkg::range_pair_type        o_active_ranges,
  // mode strap and select
  input  wire logic                              i_diff_mode_sel,
  input  wire logic                              i_cs_n,
  // single-ended pins
  input  wire logic                              i_shift_clock_in,
  input  wire logic                              i_config_serial_in,
  output logic                                   o_chan0_serial_out,
  output logic                                   o_chan0_serial_oe_n,
  output logic                                   o_chan1_serial_out,
  output logic                                   o_chan1_serial_oe_n,
  output logic                                   o_echoed_clock_out,
  // differential pins
  input  wire logic                              i_diff_shift_clock_in,
  input  wire logic                              i_diff_config_in,
  output logic                                   o_diff_serial_out,
  output logic                                   o_diff_serial_oe_n,
  output logic                                   o_diff_echoed_clock_out,
  output logic                                   o_diff_term_en
);
  import dual_adc_io_pkg::*;

  // ================================================================
  // functions
  // two's complement for bipolar codes, offset core value converted
  function automatic logic [`RES_W-1:0] format_result
  (
    input logic [`CODE_W-1:0] code,
    input logic [`RES_W-1:0]  raw
  );
    logic [`RES_W-1:0] res;
    res = raw;
    if (code == `CODE_OFF)
      res = '0;
    else if (code[`CODE_TWOS_B])
      res[`RES_W-1] = ~raw[`RES_W-1];
    return res;
  endfunction

  // ================================================================
  // pin synchronisers
  logic [`PIN_N-1:0] pins;
  logic [`PIN_N-1:0] sync1;
  logic [`PIN_N-1:0] sync2;
  logic [`PIN_N-1:0] sync3;
  logic [`PIN_N-1:0] filt;
  logic [`PIN_N-1:0] filt_d;

  // pin vector assembly
  assign pins[`PIN_CNV]  = i_convert_request;
  assign pins[`PIN_CS_N] = i_cs_n;
  assign pins[`PIN_SCK]  = i_shift_clock_in;
  assign pins[`PIN_SDI]  = i_config_serial_in;
  assign pins[`PIN_DSCK] = i_diff_shift_clock_in;
  assign pins[`PIN_DSDI] = i_diff_config_in;
  assign pins[`PIN_MODE] = i_diff_mode_sel;

  // three stages, change accepted once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < `PIN_N; g++)
    begin : g_sync
      always_ff @(posedge i_core_clk)
      begin
        if (!i_rst_n)
        begin
          sync1[g]  <= (g == `PIN_CS_N);
          sync2[g]  <= (g == `PIN_CS_N);
          sync3[g]  <= (g == `PIN_CS_N);
          filt[g]   <= (g == `PIN_CS_N);
          filt_d[g] <= (g == `PIN_CS_N);
        end
        else
        begin
          sync1[g]  <= pins[g];
          sync2[g]  <= sync1[g];
          sync3[g]  <= sync2[g];
          filt_d[g] <= filt[g];
          if (sync2[g] == sync3[g])
            filt[g] <= sync3[g];
        end
      end
    end
  endgenerate

  // ================================================================
  // decoded pin events
  logic diff;
  logic cs_n;
  logic sck;
  logic config_serial_in;
  logic sck_rise;
  logic sck_fall;
  logic cnv_rise;

  // mode strap picks lane set and clock source
  assign diff     = filt[`PIN_MODE];
  assign cs_n     = filt[`PIN_CS_N];
  assign sck      = diff ? filt[`PIN_DSCK] : filt[`PIN_SCK];
  assign config_serial_in      = diff ? filt[`PIN_DSDI] : filt[`PIN_SDI];
  // clock edges only count while selected, any idle level
  assign sck_rise = !cs_n && sck && !(diff ? filt_d[`PIN_DSCK]
                                           : filt_d[`PIN_SCK]);
  assign sck_fall = !cs_n && !sck && (diff ? filt_d[`PIN_DSCK]
                                           : filt_d[`PIN_SCK]);
  assign cnv_rise = filt[`PIN_CNV] && !filt_d[`PIN_CNV];

  // ================================================================
  // conversion sequencer
  conv_state_type            state;
  logic [`CONV_CNT_W-1:0]    conv_cnt;
  logic                      load;
  logic [`CFG_W-1:0]         cfg_shift;
  range_pair_type            ranges;

  // finishing cycle loads the output frame
  assign load = (state == CONV_RUN) && (conv_cnt == `CONV_CNT_W'(1));

  // busy over the conversion, request ignores select
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      state    <= CONV_IDLE;
      conv_cnt <= '0;
    end
    else
    begin
      case (state)
        CONV_IDLE:
          if (cnv_rise)
          begin
            state    <= CONV_RUN;
            conv_cnt <= `CONV_CNT_W'(CONV_CYCLES);
          end
        CONV_RUN:
        begin
          conv_cnt <= conv_cnt - `CONV_CNT_W'(1);
          if (load)
            state <= CONV_IDLE;
        end
        default:
          state <= CONV_IDLE;
      endcase
    end
  end

  assign o_busy = (state == CONV_RUN);

  // ================================================================
  // configuration word: msb first, channel 1 in upper bits
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      cfg_shift <= `CFG_RESET;
    else if (sck_rise || (diff && sck_fall))
      cfg_shift <= {cfg_shift[`CFG_W-2:0], config_serial_in};
  end

  // word applies from the next conversion start
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      ranges <= `CFG_RESET;
    else if (state == CONV_IDLE && cnv_rise)
      ranges <= cfg_shift;
  end

  assign o_active_ranges = ranges;

  // ================================================================
  // output frame shifter
  logic [`FRAME_W-1:0] frame;

  // load result then range per channel; shift per mode
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      frame <= '0;
    else if (load)
      frame <= {format_result(ranges.chan0, i_samples.chan0),
                ranges.chan0,
                format_result(ranges.chan1, i_samples.chan1),
                ranges.chan1};
    else if (diff && (sck_rise || sck_fall))
      frame <= {frame[`FRAME_W-2:0], 1'b0};
    else if (!diff && sck_rise)
      frame <= {frame[`LANE0_MSB-1:`LANE1_MSB+1], 1'b0,
                frame[`LANE1_MSB-1:0], 1'b0};
  end

  // ================================================================
  // echoed clocks
  logic se_echo;
  logic diff_echo;

  // half-rate toggle, cleared when busy falls
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      se_echo <= 1'b0;
    else if (load)
      se_echo <= 1'b0;
    else if (!diff && sck_rise)
      se_echo <= ~se_echo;
  end

  // full-rate copy, same pipeline depth as frame shift
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      diff_echo <= 1'b0;
    else
      diff_echo <= diff && !cs_n && sck;
  end

  // ================================================================
  // pin drivers, output enables active low, termination enable active high
  assign o_chan0_serial_out      = frame[`LANE0_MSB];
  assign o_chan1_serial_out      = frame[`LANE1_MSB];
  assign o_diff_serial_out       = frame[`LANE0_MSB];
  assign o_chan0_serial_oe_n     = cs_n || diff;
  assign o_chan1_serial_oe_n     = cs_n || diff;
  assign o_diff_serial_oe_n      = cs_n || !diff;
  assign o_echoed_clock_out      = se_echo;
  assign o_diff_echoed_clock_out = diff_echo;
  assign o_diff_term_en          = diff && !cs_n;

  // ================================================================
  // assertions
  sequence s_conv_start;
    state == CONV_IDLE && cnv_rise;
  endsequence

  sequence s_se_edge;
    !diff && sck_rise && !load;
  endsequence

  a_se_diff_hiz:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      !diff |-> o_diff_serial_oe_n && !o_diff_term_en)
    else $error("differential pins driven in single-ended mode");

  a_cs_bus_off:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      cs_n |-> o_chan0_serial_oe_n && o_chan1_serial_oe_n
               && o_diff_serial_oe_n && !sck_rise)
    else $error("bus active while select high");

  a_se_lane_shift:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      s_se_edge |=> o_chan0_serial_out == $past(frame[`LANE0_MSB-1])
                 && o_chan1_serial_out == $past(frame[`LANE1_MSB-1]))
    else $error("single-ended lanes did not advance");

  a_se_echo_half:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      s_se_edge |=> o_echoed_clock_out != $past(o_echoed_clock_out))
    else $error("echoed clock did not toggle");

  a_echo_busy_low:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      $fell(o_busy) |-> !o_echoed_clock_out)
    else $error("echoed clock not low after busy fell");

  a_cfg_sample:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (sck_rise || (diff && sck_fall))
      |=> cfg_shift == {$past(cfg_shift[`CFG_W-2:0]), $past(config_serial_in)})
    else $error("config bit not sampled");

  a_diff_one_lane:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      diff && sck_fall && !load
      |=> o_diff_serial_out == $past(frame[`LANE0_MSB-1]))
    else $error("differential lane missed a falling edge");

  a_disabled_zero:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      load && ranges.chan0 == `CODE_OFF
      |=> frame[`LANE0_MSB -: `RES_W] == '0)
    else $error("disabled channel result not zero");

  a_busy_start:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      s_conv_start |=> o_busy [*3])
    else $error("busy not raised at conversion start");

  a_diff_echo_copy:
    assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      diff && !cs_n ##1 diff && !cs_n
      |-> o_diff_echoed_clock_out == $past(sck))
    else $error("differential echoed clock not a copy");

endmodule

// [sim/adc_serial_host_model.sv]
// host model for the converter serial port: select, clocks, config, capture
`timescale 1ns/100ps
module adc_serial_host_model
(
  // core clock paces the ddr capture
  input  wire logic i_core_clk,
  // converter outputs
  input  wire logic i_lane0,
  input  wire logic i_lane1,
  input  wire logic i_dlane,
  input  wire logic i_dech,
  input  wire logic i_ech,
  // host pins
  output logic      o_cs_n,
  output logic      o_sck,
  output logic      o_sdi,
  output logic      o_dsck,
  output logic      o_dsdi
);
  logic [37:0] gs0, gs1, gd, ge;
  logic        dgo, dech_q, dlane_q, ech_q, lane0_q;
  // ==================================================================
  // idle levels at time zero
  initial
  begin
    {o_cs_n, o_sck, o_sdi, o_dsck, o_dsdi} = 5'h10;
    dgo = 1'b0;
  end
  // ddr capture of the lane value held just before each echo edge
  always @(negedge i_core_clk)
  begin
    if (dgo && i_dech !== dech_q) gd = {gd[36:0], dlane_q};
    if (dgo && i_ech !== ech_q) ge = {ge[36:0], lane0_q};
    dech_q  = i_dech;
    dlane_q = i_dlane;
    ech_q   = i_ech;
    lane0_q = i_lane0;
  end
  // one frame: config word out msb first, lanes captured
  task automatic xfer(input logic dm, input logic ih, input logic [5:0] w);
    logic [37:0] sr;
    int          j;
    logic        act;
    sr  = {32'h0, w};
    j   = dm ? 37 : 18;
    gs0 = '0;
    gs1 = '0;
    gd  = '0;
    ge  = '0;
    if (!dm)
    begin
      // stray edges while deselected must leave no trace
      repeat (3)
      begin
        o_sck = ~o_sck;
        #24;
      end
      o_sck = ih;
      #48;
    end
    else
      #120; // differential clock parked low
    o_cs_n = 1'b0;
    dgo    = 1'b1;
    #40;
    repeat (38)
    begin
      act = dm | ~o_sck;
      #12;
      if (act)
      begin
        o_sdi  = sr[j];
        o_dsdi = sr[j];
        j--;
      end
      #12;
      if (act & ~dm)
      begin
        gs0 = {gs0[36:0], i_lane0};
        gs1 = {gs1[36:0], i_lane1};
      end
      if (dm) o_dsck = ~o_dsck;
      else o_sck = ~o_sck;
    end
    #40;
    dgo    = 1'b0;
    o_cs_n = 1'b1;
    // released config lines flip so a late sample shows up
    o_sdi  = ~o_sdi;
    o_dsdi = ~o_dsdi;
  endtask
endmodule

// [sim/test_dual_adc_serial_io_config.sv]
// self-checking bench for the dual converter serial port
`timescale 1ns/100ps
module test_dual_adc_serial_io_config;
  import dual_adc_io_pkg::*;
  localparam int CONV = 20;
  logic            clk, rst_n, req, dsel, busy;
  sample_pair_type samples, ps;
  range_pair_type  ranges;
  logic            l0, oe0, l1, oe1, ech, dl, doe, dech, term;
  logic            cs_n, sck, config_serial_in, dsck, dsdi;
  logic [5:0]      w, pw;
  int              n_fail, checked, cyc, ne, nd;
  // ==================================================================
  // design and host model
  dual_adc_serial_io_config #(.CONV_CYCLES(CONV)) u_dut
  (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_samples(samples),
    .i_convert_request(req), .o_busy(busy), .o_active_ranges(ranges),
    .i_diff_mode_sel(dsel), .i_cs_n(cs_n), .i_shift_clock_in(sck),
    .i_config_serial_in(config_serial_in), .o_chan0_serial_out(l0),
    .o_chan0_serial_oe_n(oe0), .o_chan1_serial_out(l1),
    .o_chan1_serial_oe_n(oe1), .o_echoed_clock_out(ech),
    .i_diff_shift_clock_in(dsck), .i_diff_config_in(dsdi),
    .o_diff_serial_out(dl), .o_diff_serial_oe_n(doe),
    .o_diff_echoed_clock_out(dech), .o_diff_term_en(term)
  );
  adc_serial_host_model u_host
  (
    .i_core_clk(clk), .i_lane0(l0), .i_lane1(l1), .i_dlane(dl),
    .i_dech(dech), .i_ech(ech), .o_cs_n(cs_n), .o_sck(sck),
    .o_sdi(config_serial_in), .o_dsck(dsck), .o_dsdi(dsdi)
  );
  // clock, echo edge counters and hang guard
  always #2.5 clk = ~clk;
  always @(ech) ne++;
  always @(posedge dech) nd++;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      n_fail++;
      print_verdict;
    end
  end
  // expected channel frame: result then range code
  function automatic logic [18:0] fmt(input logic [2:0] c,
                                      input logic [15:0] r);
    if (c == 3'h0) return 19'h0;
    return {c[1] ? {~r[15], r[14:0]} : r, c};
  endfunction
  task automatic compare(input logic [37:0] seen, input logic [37:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checked %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // conversion with a second request edge dropped while busy
  task automatic conv(input logic [5:0] wc);
    int n;
    int extra;
    n     = 0;
    extra = 0;
    fork
      repeat (2)
      begin
        @(posedge clk) #1 req = 1'b1;
        repeat (6) @(posedge clk);
        #1 req = 1'b0;
        repeat (5) @(posedge clk);
      end
      begin
        for (int k = 0; k < 20 && busy !== 1'b1; k++) @(negedge clk);
        while (busy === 1'b1 && n < 100)
        begin
          @(negedge clk);
          n++;
        end
      end
    join
    repeat (30)
    begin
      @(negedge clk);
      if (busy !== 1'b0) extra++;
    end
    compare(38'(n), 38'(CONV));
    compare(38'(extra), 38'h0);
    compare(ech, 1'b0);
    compare(ranges, wc);
  endtask
  // ==================================================================
  // main sequence
  initial
  begin
    {clk, rst_n, req, dsel} = 4'h0;
    samples = 32'h1234_9abc;
    pw = 6'h3f;
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (8) @(posedge clk);
    compare({oe0, oe1, doe, term, busy}, 5'h1c);
    conv(6'h3f);
    for (int i = 0; i < 9; i++)
    begin
      w  = {i[2:0], 3'h7 - i[2:0]};
      ps = samples;
      @(posedge clk) #1 dsel = i[0];
      repeat (8) @(posedge clk);
      ne = 0;
      nd = 0;
      fork
        u_host.xfer(i[0], i[1], w);
        #200 compare({oe0, oe1, doe, term}, i[0] ? 4'hd : 4'h2);
      join
      repeat (8) @(negedge clk);
      compare({oe0, oe1, doe, term}, 4'he);
      if (i[0])
      begin
        compare(u_host.gd, {fmt(pw[2:0], ps.chan0),
                            fmt(pw[5:3], ps.chan1)});
        compare(38'(nd), 38'd19);
      end
      else
      begin
        compare(u_host.gs0, fmt(pw[2:0], ps.chan0));
        compare(u_host.gs1, fmt(pw[5:3], ps.chan1));
        compare(38'(ne), 38'd19);
        compare(u_host.ge, fmt(pw[2:0], ps.chan0));
      end
      @(posedge clk) #1 samples = {i[1:0], 14'h1a3c, ~i[1:0], 14'h25c3};
      if (i == 7) u_host.o_cs_n = 1'b0;
      conv(w);
      @(posedge clk) #1 u_host.o_cs_n = 1'b1;
      pw = w;
    end
    print_verdict;
  end
endmodule
